// ===== core/port_six_serial_mux.sv
// Purpose: six-pin general port whose pins are shared with two serial channels
// Assumes: serial control bits and standby levels come from logic on i_mclk
// Notes: pin drivers are registered, so a change reaches the pins one cycle later
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/100ps
module port_six_serial_mux
    import port_six_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [DATA_W-1:0] o_rdata,
    input wire logic i_sw_standby,
    input wire logic i_hw_standby,
    input wire logic [1:0] i_clk_sel_low,
    input wire logic [1:0] i_clk_sel_high,
    input wire logic [1:0] i_sync_mode,
    input wire logic [1:0] i_rx_on,
    input wire logic [1:0] i_tx_on,
    input wire logic i_smartcard_sel,
    input wire logic [1:0] i_serial_clk_out,
    input wire logic i_tx_line_zero,
    input wire logic i_tx_line_one,
    input wire logic i_tx_drive_zero,
    output logic o_serial_clk_pin_zero,
    output logic o_serial_clk_pin_one,
    output logic o_rx_line_zero,
    output logic o_rx_line_one,
    output logic o_ext_interrupt_four,
    output logic o_ext_interrupt_five,
    input wire logic [PIN_COUNT-1:0] i_pin_in,
    output logic [PIN_COUNT-1:0] o_pin_out,
    output logic [PIN_COUNT-1:0] o_pin_oe
);
    logic [DATA_W-1:0] dir_reg;
    logic [DATA_W-1:0] latch_reg;
    logic [DATA_W-1:0] rdata_next;
    logic [PIN_COUNT-1:0] pin_level;
    logic [PIN_COUNT-1:0] out_next;
    logic [PIN_COUNT-1:0] oe_next;
    pin_func_type func [PIN_COUNT];

    function automatic logic hit_dir(input logic [ADDR_W-1:0] addr);
        return addr == DIR_OFFSET;
    endfunction

    function automatic logic hit_latch(input logic [ADDR_W-1:0] addr);
        return addr == LATCH_OFFSET;
    endfunction

    // clock pin choice shared by both channels
    function automatic pin_func_type clk_pin_func(input logic hi, input logic sync, input logic lo);
        if (hi) begin
            return FUNC_SERIAL_IN;
        end else if (sync || lo) begin
            return FUNC_SERIAL_OUT;
        end else begin
            return FUNC_PORT;
        end
    endfunction

    pin_level_sync u_sync (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_async(i_pin_in),
        .o_level(pin_level)
    );

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dir_reg <= DIR_RESET;
        end else if (i_hw_standby) begin
            dir_reg <= DIR_RESET;
        end else if (i_wr && hit_dir(i_addr)) begin
            dir_reg <= i_wdata | RESERVED_ONES;
        end
    end

    // latch store, reserved bits stay one
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            latch_reg <= LATCH_RESET;
        end else if (i_hw_standby) begin
            latch_reg <= LATCH_RESET;
        end else if (i_wr && hit_latch(i_addr)) begin
            latch_reg <= i_wdata | RESERVED_ONES;
        end
    end

    always_comb begin
        if (hit_dir(i_addr)) begin
            rdata_next = DIR_READ_VALUE;
        end else if (hit_latch(i_addr)) begin
            rdata_next = RESERVED_ONES;
            rdata_next[PIN_COUNT-1:0] = (dir_reg[PIN_COUNT-1:0] & latch_reg[PIN_COUNT-1:0])
                | (~dir_reg[PIN_COUNT-1:0] & pin_level);
        end else begin
            rdata_next = UNMAPPED_READ;
        end
    end

    // data only valid in the cycle after the strobe
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= UNMAPPED_READ;
        end else if (i_rd) begin
            o_rdata <= rdata_next;
        end else begin
            o_rdata <= UNMAPPED_READ;
        end
    end

    // the sync-mode and smart card mode inputs take part in selection
    always_comb begin
        func[PIN_SCK_ONE] = clk_pin_func(i_clk_sel_high[CH_ONE], i_sync_mode[CH_ONE], i_clk_sel_low[CH_ONE]);
        func[PIN_SCK_ZERO] = clk_pin_func(i_clk_sel_high[CH_ZERO], i_sync_mode[CH_ZERO],
            i_clk_sel_low[CH_ZERO]);
        func[PIN_RX_ONE] = i_rx_on[CH_ONE] ? FUNC_SERIAL_IN : FUNC_PORT;
        func[PIN_RX_ZERO] = (i_smartcard_sel || i_rx_on[CH_ZERO]) ? FUNC_SERIAL_IN : FUNC_PORT;
        func[PIN_TX_ONE] = i_tx_on[CH_ONE] ? FUNC_SERIAL_OUT : FUNC_PORT;
        func[PIN_TX_ZERO] = (i_smartcard_sel || i_tx_on[CH_ZERO]) ? FUNC_SERIAL_OUT : FUNC_PORT;
    end

    always_comb begin
        for (int i = 0; i < PIN_COUNT; i++) begin
            case (func[i])
                FUNC_SERIAL_IN: begin
                    out_next[i] = 1'b0;
                    oe_next[i] = 1'b0;
                end
                FUNC_SERIAL_OUT: begin
                    out_next[i] = 1'b0;
                    oe_next[i] = 1'b1;
                end
                default: begin
                    out_next[i] = latch_reg[i];
                    oe_next[i] = dir_reg[i];
                end
            endcase
        end
        out_next[PIN_SCK_ONE] = (func[PIN_SCK_ONE] == FUNC_SERIAL_OUT) ? i_serial_clk_out[CH_ONE]
            : out_next[PIN_SCK_ONE];
        out_next[PIN_SCK_ZERO] = (func[PIN_SCK_ZERO] == FUNC_SERIAL_OUT) ? i_serial_clk_out[CH_ZERO]
            : out_next[PIN_SCK_ZERO];
        out_next[PIN_TX_ONE] = (func[PIN_TX_ONE] == FUNC_SERIAL_OUT) ? i_tx_line_one : out_next[PIN_TX_ONE];
        out_next[PIN_TX_ZERO] = (func[PIN_TX_ZERO] == FUNC_SERIAL_OUT) ? i_tx_line_zero : out_next[PIN_TX_ZERO];
        // smart card transmit released when channel asks
        if (i_smartcard_sel) begin
            oe_next[PIN_TX_ZERO] = i_tx_drive_zero;
        end
    end

    // drivers frozen in software standby; hardware standby floats all
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pin_out <= PIN_RESET;
            o_pin_oe <= PIN_RESET;
        end else if (i_hw_standby) begin
            o_pin_out <= PIN_RESET;
            o_pin_oe <= PIN_RESET;
        end else if (!i_sw_standby) begin
            o_pin_out <= out_next;
            o_pin_oe <= oe_next;
        end
    end

    // idle-high receive and clock lines unless the pin is set as a serial input
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rx_line_one <= 1'b1;
            o_rx_line_zero <= 1'b1;
            o_serial_clk_pin_one <= 1'b1;
            o_serial_clk_pin_zero <= 1'b1;
        end else begin
            o_rx_line_one <= (func[PIN_RX_ONE] == FUNC_SERIAL_IN) ? pin_level[PIN_RX_ONE] : 1'b1;
            o_rx_line_zero <= (func[PIN_RX_ZERO] == FUNC_SERIAL_IN) ? pin_level[PIN_RX_ZERO] : 1'b1;
            o_serial_clk_pin_one <= (func[PIN_SCK_ONE] == FUNC_SERIAL_IN) ? pin_level[PIN_SCK_ONE] : 1'b1;
            o_serial_clk_pin_zero <= (func[PIN_SCK_ZERO] == FUNC_SERIAL_IN) ? pin_level[PIN_SCK_ZERO] : 1'b1;
        end
    end

    // interrupt inputs see the pin whatever its role
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_ext_interrupt_five <= 1'b1;
            o_ext_interrupt_four <= 1'b1;
        end else begin
            o_ext_interrupt_five <= pin_level[PIN_SCK_ONE];
            o_ext_interrupt_four <= pin_level[PIN_SCK_ZERO];
        end
    end

    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    logic port_ok;
    assign port_ok = !i_sw_standby && !i_hw_standby;

    dir_output_a: assert property (
        (port_ok && !i_rx_on[CH_ONE] && dir_reg[PIN_RX_ONE]) |=> o_pin_oe[PIN_RX_ONE]
            && (o_pin_out[PIN_RX_ONE] == $past(latch_reg[PIN_RX_ONE])))
        else $error("output pin not driven from latch");

    dir_input_a: assert property (
        (port_ok && !i_rx_on[CH_ONE] && !dir_reg[PIN_RX_ONE]) |=> !o_pin_oe[PIN_RX_ONE])
        else $error("input pin is driven");

    dir_reserved_a: assert property (
        dir_reg[7:6] == 2'b11)
        else $error("direction reserved bits not one");

    dir_read_ones_a: assert property (
        (i_rd && hit_dir(i_addr)) |=> o_rdata == DIR_READ_VALUE)
        else $error("direction read not all ones");

    dir_hw_reset_a: assert property (
        i_hw_standby |=> dir_reg == DIR_RESET)
        else $error("direction not reset in hardware standby");

    sw_hold_a: assert property (
        (i_sw_standby && !i_hw_standby) |=> $stable(o_pin_out) && $stable(o_pin_oe))
        else $error("pins changed in software standby");

    latch_read_a: assert property (
        (i_rd && hit_latch(i_addr)) |=> o_rdata[5:0] == (($past(dir_reg[5:0]) & $past(latch_reg[5:0]))
            | (~$past(dir_reg[5:0]) & $past(pin_level))))
        else $error("data read mixes latch and pins wrongly");

    latch_reserved_a: assert property (
        (i_rd && hit_latch(i_addr)) |=> o_rdata[7:6] == 2'b11)
        else $error("data reserved bits not one");

    latch_hw_reset_a: assert property (
        i_hw_standby |=> latch_reg == LATCH_RESET)
        else $error("latch not reset in hardware standby");

    sck_input_a: assert property (
        (port_ok && i_clk_sel_high[CH_ONE]) |=> !o_pin_oe[PIN_SCK_ONE]
            && (o_serial_clk_pin_one == $past(pin_level[PIN_SCK_ONE])))
        else $error("clock input pin driven or not passed on");

    sck_output_a: assert property (
        (port_ok && !i_clk_sel_high[CH_ZERO] && (i_sync_mode[CH_ZERO] || i_clk_sel_low[CH_ZERO]))
            |=> o_pin_oe[PIN_SCK_ZERO] && o_pin_out[PIN_SCK_ZERO] == $past(i_serial_clk_out[CH_ZERO]))
        else $error("clock output pin not driven");

    irq_follow_a: assert property (
        ##1 (o_ext_interrupt_five == $past(pin_level[PIN_SCK_ONE])
            && o_ext_interrupt_four == $past(pin_level[PIN_SCK_ZERO])))
        else $error("interrupt input lost pin level");

    rx_one_a: assert property (
        (port_ok && i_rx_on[CH_ONE]) |=> !o_pin_oe[PIN_RX_ONE])
        else $error("receive pin one driven");

    rx_zero_a: assert property (
        (port_ok && (i_smartcard_sel || i_rx_on[CH_ZERO])) |=> !o_pin_oe[PIN_RX_ZERO])
        else $error("receive pin zero driven");

    tx_one_a: assert property (
        (port_ok && i_tx_on[CH_ONE]) |=> o_pin_oe[PIN_TX_ONE] && o_pin_out[PIN_TX_ONE] == $past(i_tx_line_one))
        else $error("transmit pin one not driven");

    tx_zero_a: assert property (
        (port_ok && !i_smartcard_sel && i_tx_on[CH_ZERO])
            |=> o_pin_oe[PIN_TX_ZERO] && o_pin_out[PIN_TX_ZERO] == $past(i_tx_line_zero))
        else $error("transmit pin zero not driven");

    smart_release_a: assert property (
        (port_ok && i_smartcard_sel) |=> o_pin_oe[PIN_TX_ZERO] == $past(i_tx_drive_zero))
        else $error("smart card drive state wrong");

    owned_keep_a: assert property (
        (i_tx_on[CH_ONE] && !i_wr && !i_hw_standby) |=> $stable(latch_reg) && $stable(dir_reg))
        else $error("serial use altered port registers");

    smart_release_c: cover property (port_ok && i_smartcard_sel && !i_tx_drive_zero ##1 !o_pin_oe[PIN_TX_ZERO]);
    dir_read_c: cover property (i_rd && hit_dir(i_addr));
    sw_hold_c: cover property ((i_sw_standby && o_pin_oe != PIN_RESET) [*3]);
    sck_input_c: cover property (port_ok && i_clk_sel_high[CH_ONE] ##2 !o_serial_clk_pin_one);
endmodule

// ===== core/port_six_pkg.sv
// Purpose: shared constants for the six-pin port with serial pin sharing
// Assumes: 16-bit register address, 8-bit register data
// Notes: pin indices name the shared function on each pin
package port_six_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int PIN_COUNT = 6;

    localparam logic [15:0] DIR_OFFSET = 16'hFFD0;
    localparam logic [15:0] LATCH_OFFSET = 16'hFFD2;

    localparam logic [7:0] DIR_RESET = 8'hC0;
    localparam logic [7:0] LATCH_RESET = 8'hC0;
    localparam logic [7:0] RESERVED_ONES = 8'hC0;
    localparam logic [7:0] DIR_READ_VALUE = 8'hFF;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    localparam logic [5:0] PIN_RESET = 6'h00;
    localparam logic [5:0] LEVEL_RESET = 6'h3F;

    localparam int PIN_TX_ZERO = 0;
    localparam int PIN_TX_ONE = 1;
    localparam int PIN_RX_ZERO = 2;
    localparam int PIN_RX_ONE = 3;
    localparam int PIN_SCK_ZERO = 4;
    localparam int PIN_SCK_ONE = 5;

    localparam int CH_ZERO = 0;
    localparam int CH_ONE = 1;

    typedef enum logic [1:0] {
        FUNC_PORT,
        FUNC_SERIAL_IN,
        FUNC_SERIAL_OUT
    } pin_func_type;
endpackage

// ===== core/pin_level_sync.sv
// Purpose: bring the asynchronous pin levels into the clock domain
// Assumes: pins may change at any time
// Notes: a new level is accepted once the second and third stages agree
`timescale 1ns/100ps
module pin_level_sync
    import port_six_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic [PIN_COUNT-1:0] i_async,
    output logic [PIN_COUNT-1:0] o_level
);
    logic [PIN_COUNT-1:0] stage1_reg;
    logic [PIN_COUNT-1:0] stage2_reg;
    logic [PIN_COUNT-1:0] stage3_reg;

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            stage1_reg <= LEVEL_RESET;
            stage2_reg <= LEVEL_RESET;
            stage3_reg <= LEVEL_RESET;
        end else begin
            stage1_reg <= i_async;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // per bit: stage1 feeds only stage2
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_level <= LEVEL_RESET;
        end else begin
            for (int i = 0; i < PIN_COUNT; i++) begin
                if (stage2_reg[i] == stage3_reg[i]) begin
                    o_level[i] <= stage3_reg[i];
                end
            end
        end
    end
endmodule

// ===== sim/pin_partner.sv
// Purpose: far side of the six pins, external drivers seen by the port
// Assumes: an outside party holds a level on every pin the port releases
// Notes: a pin the port drives reads back its own output level
`timescale 1ns/100ps
module pin_partner
    import port_six_pkg::*;
(
    input wire logic [PIN_COUNT-1:0] i_pin_out,
    input wire logic [PIN_COUNT-1:0] i_pin_oe,
    input wire logic [PIN_COUNT-1:0] i_ext_level,
    output logic [PIN_COUNT-1:0] o_pin_level
);
    // resolved pin level
    // port driver wins, a released pin shows the outside level
    assign o_pin_level = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_ext_level);
endmodule

// ===== sim/tb_top.sv
// Purpose: self-checking bench for the six-pin port with serial sharing
// Assumes: outside levels 2A on pins 5..0 unless a test says otherwise
// Notes: settle waits cover the pin synchroniser and registered drivers
`timescale 1ns/100ps
module tb_top;
    import port_six_pkg::*;
    logic mclk, rst_n, wr, rd, sw, hw, sc, txl0, txl1, txdrv0;
    logic [15:0] addr;
    logic [7:0] wdata, rdata;
    logic [1:0] cks_lo, cks_hi, sync, rx_on, tx_on, sclk_out;
    logic serial_clk_pin_zero, serial_clk_pin_one, rxl0, rxl1, ext_interrupt_four, ext_interrupt_five;
    logic [5:0] pin_in, pin_out, pin_oe, ext;
    int error_cnt = 0;
    int n_tests = 0;

    port_six_serial_mux i_dut (.i_mclk(mclk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_sw_standby(sw), .i_hw_standby(hw),
        .i_clk_sel_low(cks_lo), .i_clk_sel_high(cks_hi), .i_sync_mode(sync), .i_rx_on(rx_on),
        .i_tx_on(tx_on), .i_smartcard_sel(sc), .i_serial_clk_out(sclk_out), .i_tx_line_zero(txl0),
        .i_tx_line_one(txl1), .i_tx_drive_zero(txdrv0), .o_serial_clk_pin_zero(serial_clk_pin_zero),
        .o_serial_clk_pin_one(serial_clk_pin_one), .o_rx_line_zero(rxl0), .o_rx_line_one(rxl1),
        .o_ext_interrupt_four(ext_interrupt_four), .o_ext_interrupt_five(ext_interrupt_five), .i_pin_in(pin_in),
        .o_pin_out(pin_out), .o_pin_oe(pin_oe));
    pin_partner i_pins (.i_pin_out(pin_out), .i_pin_oe(pin_oe), .i_ext_level(ext), .o_pin_level(pin_in));

    always #10 mclk = ~mclk;

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input string name, input logic [15:0] a, input logic [7:0] exp);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        chk(name, exp, rdata);
    endtask

    // eight edges outlast the four-edge synchroniser path
    task automatic settle();
        repeat (8) @(posedge mclk);
        #1;
    endtask

    task automatic t_reset();
        settle();
        rd_chk("dir_rd", DIR_OFFSET, 8'hFF);
        rd_chk("latch_rd", LATCH_OFFSET, 8'hEA);
        rd_chk("unmapped", 16'hFFD4, 8'h00);
        chk("oe", 8'h00, {2'b00, pin_oe});
        $display("test reset done");
    endtask

    task automatic t_port();
        wr_reg(DIR_OFFSET, 8'h0F);
        wr_reg(LATCH_OFFSET, 8'h15);
        settle();
        chk("oe", 8'h0F, {2'b00, pin_oe});
        chk("out", 8'h05, {2'b00, pin_out & pin_oe});
        rd_chk("mixed_rd", LATCH_OFFSET, 8'hE5);
        wr_reg(DIR_OFFSET, 8'h3F);
        rd_chk("dir_rd", DIR_OFFSET, 8'hFF);
        rd_chk("latch_rd", LATCH_OFFSET, 8'hD5);
        wr_reg(LATCH_OFFSET, 8'h00);
        rd_chk("resv_rd", LATCH_OFFSET, 8'hC0);
        $display("test port done");
    endtask

    task automatic t_serial();
        @(posedge mclk);
        tx_on <= 2'b11;
        txl1 <= 1'b1;
        txl0 <= 1'b1;
        rx_on <= 2'b11;
        cks_hi <= 2'b10;
        sync <= 2'b01;
        sclk_out <= 2'b01;
        // low outside levels so passed-on lines differ from their idle one
        ext <= 6'h02;
        settle();
        chk("oe", 8'h13, {2'b00, pin_oe});
        chk("out", 8'h13, {2'b00, pin_out & pin_oe});
        chk("rx", 8'h00, {6'h00, rxl1, rxl0});
        chk("serial_clk_pin_one", 8'h00, {7'h00, serial_clk_pin_one});
        chk("irq", 8'h01, {6'h00, ext_interrupt_five, ext_interrupt_four});
        rd_chk("latch_kept", LATCH_OFFSET, 8'hC0);
        @(posedge mclk);
        ext <= 6'h2A;
        sync <= 2'b00;
        cks_lo <= 2'b01;
        tx_on <= 2'b00;
        rx_on <= 2'b00;
        sc <= 1'b1;
        txdrv0 <= 1'b0;
        settle();
        chk("oe_sc_off", 8'h1A, {2'b00, pin_oe});
        chk("rx0_sc", 8'h00, {7'h00, rxl0});
        @(posedge mclk);
        txdrv0 <= 1'b1;
        settle();
        chk("oe_sc_on", 8'h1B, {2'b00, pin_oe});
        chk("out_sc", 8'h11, {2'b00, pin_out & pin_oe});
        @(posedge mclk);
        sc <= 1'b0;
        cks_lo <= 2'b00;
        cks_hi <= 2'b01;
        sync <= 2'b10;
        sclk_out <= 2'b10;
        settle();
        chk("oe_ck", 8'h2F, {2'b00, pin_oe});
        chk("out_ck", 8'h20, {2'b00, pin_out & pin_oe});
        chk("serial_clk_pin_zero", 8'h00, {7'h00, serial_clk_pin_zero});
        chk("serial_clk_pin_one_idle", 8'h01, {7'h00, serial_clk_pin_one});
        chk("irq_ck", 8'h02, {6'h00, ext_interrupt_five, ext_interrupt_four});
        @(posedge mclk);
        cks_hi <= 2'b00;
        sync <= 2'b00;
        $display("test serial done");
    endtask

    task automatic t_standby();
        wr_reg(LATCH_OFFSET, 8'h2A);
        settle();
        @(posedge mclk);
        sw <= 1'b1;
        wr_reg(LATCH_OFFSET, 8'h15);
        settle();
        chk("frozen", 8'h2A, {2'b00, pin_out});
        rd_chk("latch_sw", LATCH_OFFSET, 8'hD5);
        @(posedge mclk);
        sw <= 1'b0;
        settle();
        chk("thawed", 8'h15, {2'b00, pin_out});
        @(posedge mclk);
        hw <= 1'b1;
        wr_reg(DIR_OFFSET, 8'h3F);
        settle();
        rd_chk("latch_hw", LATCH_OFFSET, 8'hEA);
        @(posedge mclk);
        hw <= 1'b0;
        settle();
        chk("oe_hw", 8'h00, {2'b00, pin_oe});
        $display("test standby done");
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        rst_n = 1'b0;
        {wr, rd, sw, hw, sc, txl0, txl1, txdrv0} = 8'h00;
        {cks_lo, cks_hi, sync, rx_on, tx_on, sclk_out} = 12'h000;
        addr = 16'h0000;
        wdata = 8'h00;
        ext = 6'h2A;
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_port();
        t_serial();
        t_standby();
        summarize();
    end

    // tests need well under a thousand cycles
    initial begin
        repeat (5000) @(posedge mclk);
        error_cnt++;
        summarize();
    end
endmodule
